// >>> common/rcotp_pkg.sv
`default_nettype none
package rcotp_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 24;
  localparam logic [4:0] ADDR_CAL_STROBE = 5'h04;
  localparam logic [4:0] ADDR_REF_PERIOD = 5'h05;
  localparam logic [4:0] ADDR_CORRECTION = 5'h06;
  localparam logic [4:0] ADDR_CAL_STATUS = 5'h08;
  localparam logic [4:0] ADDR_RAW_COUNT = 5'h09;
  localparam logic [4:0] ADDR_STORED = 5'h0A;
  localparam logic [4:0] ADDR_BURN_ENABLE = 5'h0B;
  localparam logic [4:0] ADDR_BURN_ADDR = 5'h0C;
  localparam logic [4:0] ADDR_BURN_STROBE = 5'h0D;
  localparam logic [4:0] ADDR_ST_ENABLE = 5'h0E;
  localparam logic [4:0] ADDR_ST_RESULT = 5'h0F;
  localparam int REF_PERIOD_W = 15;
  localparam int CORR_W = 9;
  localparam int FINE_W = 4;
  localparam int RAW_W = 24;
  localparam int SIG_W = 16;
  localparam int NVM_ADDR_W = 4;
  localparam int NVM_BITS = 16;
  localparam int STORED_USED_W = 15;
  localparam int STATUS_CAL_BUSY_BIT = 4;
  localparam int STATUS_BURN_BIT = 5;
  localparam int STORED_PRG_FLAG_BIT = 13;
  localparam int ST_RUN_BIT = 16;
  localparam logic [3:0] FINE_MAX = 4'hB;
  localparam logic [14:0] REF_PERIOD_RST = 15'h0000;
  localparam logic [8:0] CORR_RST = 9'h000;
  localparam logic [3:0] BURN_ADDR_RST = 4'h0;
  localparam logic [15:0] SIG_RST = 16'h0000;
  localparam logic [23:0] RAW_RST = 24'h000000;
  localparam int CORR_STEP_PS = 1024;
  localparam int CORR_SHIFT = $clog2(CORR_STEP_PS);
  localparam logic [25:0] FINE_BASE_PS = 26'h0186A0;
  localparam logic [25:0] FINE_STEP_PS = 26'h002710;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int BURN_TIME_NS = 10000;
  localparam int BURN_CYCLES = (BURN_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [9:0] BURN_LAST = 10'(BURN_CYCLES - 1);
  localparam logic [11:0] CAL_TIMEOUT_LAST = 12'hFFF;
  localparam logic [11:0] SELF_TEST_LAST = 12'h0FF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  function automatic logic [25:0] adjust(input logic [23:0] raw, input logic [8:0] corr);
    logic [25:0] sx;
    sx = {{17{corr[8]}}, corr};
    return {2'b00, raw} + (sx << CORR_SHIFT);
  endfunction

  function automatic logic [3:0] fine_decode(input logic [25:0] adj);
    logic [3:0] code;
    logic [25:0] thr;
    code = 4'h0;
    thr = FINE_BASE_PS;
    for (int k = 1; k <= 11; k++) begin
      thr = thr + FINE_STEP_PS;
      if (!adj[25] && adj >= thr) begin
        code = 4'(k);
      end
    end
    return code;
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] data);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// >>> common/rcotp_eng_if.sv
`default_nettype none
interface rcotp_eng_if;
  logic start;
  logic self_test;
  logic [14:0] ref_period;
  logic [8:0] correction;
  logic cal_busy;
  logic st_running;
  logic [23:0] raw_count;
  logic [3:0] fine_code;
  logic [15:0] signature;
  modport ctrl (output start, self_test, ref_period, correction,
    input cal_busy, st_running, raw_count, fine_code, signature);
  modport engine (input start, self_test, ref_period, correction,
    output cal_busy, st_running, raw_count, fine_code, signature);
endinterface
`default_nettype wire

// >>> hdl/rcotp_engine.sv
`default_nettype none
module rcotp_engine (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_rc_threshold,
  rcotp_eng_if.engine bus
);
  typedef enum logic [1:0] {ENG_IDLE, ENG_MEASURE, ENG_SELF_TEST} rcotp_eng_state_t;
  typedef struct packed {
    rcotp_eng_state_t st;
    logic [11:0] cnt;
    logic [23:0] acc;
    logic [15:0] crc;
    logic [8:0] corr;
    logic s1;
    logic s2;
    logic s3;
    logic cal_busy;
    logic st_running;
    logic [23:0] raw;
    logic [3:0] fine;
    logic [15:0] sig;
  } rcotp_eng_t;
  rcotp_eng_t q;
  rcotp_eng_t n;

  always_comb begin
    n = q;
    n.s1 = i_rc_threshold;
    n.s2 = q.s1;
    n.s3 = q.s2;
    unique case (q.st)
      ENG_IDLE: begin
        if (bus.start) begin
          n.cnt = 12'h000;
          n.acc = 24'h000000;
          n.corr = bus.correction;
          n.cal_busy = 1'b1;
          if (bus.self_test) begin
            n.st = ENG_SELF_TEST;
            n.crc = rcotp_pkg::CRC_INIT;
            n.st_running = 1'b1;
          end else begin
            n.st = ENG_MEASURE;
          end
        end
      end
      ENG_MEASURE: begin
        n.acc = q.acc + {9'h000, bus.ref_period};
        n.cnt = q.cnt + 12'h001;
        if ((q.s2 && q.s3) || q.cnt == rcotp_pkg::CAL_TIMEOUT_LAST) begin
          n.st = ENG_IDLE;
          n.cal_busy = 1'b0;
          n.raw = q.acc;
          n.fine = rcotp_pkg::fine_decode(rcotp_pkg::adjust(q.acc, q.corr));
        end
      end
      ENG_SELF_TEST: begin
        n.acc = q.acc + {9'h000, bus.ref_period};
        n.crc = rcotp_pkg::crc_step(q.crc, q.acc[15:0] ^ q.acc[23:8]);
        n.cnt = q.cnt + 12'h001;
        if (q.cnt == rcotp_pkg::SELF_TEST_LAST) begin
          n.st = ENG_IDLE;
          n.cal_busy = 1'b0;
          n.st_running = 1'b0;
          n.sig = n.crc;
          n.raw = q.acc;
          n.fine = rcotp_pkg::fine_decode(rcotp_pkg::adjust(q.acc, q.corr));
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '{st: ENG_IDLE, cnt: 12'h000, acc: rcotp_pkg::RAW_RST, crc: rcotp_pkg::CRC_INIT,
        corr: rcotp_pkg::CORR_RST, s1: 1'b0, s2: 1'b0, s3: 1'b0, cal_busy: 1'b0,
        st_running: 1'b0, raw: rcotp_pkg::RAW_RST, fine: 4'h0, sig: rcotp_pkg::SIG_RST};
    end else begin
      q <= n;
    end
  end

  assign bus.cal_busy = q.cal_busy;
  assign bus.st_running = q.st_running;
  assign bus.raw_count = q.raw;
  assign bus.fine_code = q.fine;
  assign bus.signature = q.sig;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  fine_decode_check_a: assert property ($fell(q.cal_busy) |-> q.fine ==
    rcotp_pkg::fine_decode(rcotp_pkg::adjust($past(q.acc), q.corr)) && q.raw == $past(q.acc))
    else $error("fine code or raw count wrong at calibration end");
  self_test_length_a: assert property ($rose(q.st_running) |-> q.st_running [*8])
    else $error("self-test busy dropped too early");
  self_test_sig_a: assert property ($fell(q.st_running) |-> !q.cal_busy && q.sig == q.crc)
    else $error("self-test signature not captured at end");
  cover_self_test_c: cover property ($fell(q.st_running));
endmodule
`default_nettype wire

// >>> hdl/rcotp_regs.sv
`default_nettype none
module rcotp_regs (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [4:0] i_reg_addr,
  input wire logic [23:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic i_rc_threshold,
  input wire logic [15:0] i_nvm_bits,
  input wire logic i_ignore_stored_values,
  input wire logic i_force_fine,
  input wire logic [3:0] i_fine_override,
  output logic [23:0] o_reg_rdata,
  output logic [3:0] o_fine_code,
  output logic o_use_stored,
  output logic o_nvm_burn_pulse,
  output logic [3:0] o_nvm_burn_addr
);
  typedef struct packed {
    logic [14:0] ref_period;
    logic [8:0] correction;
    logic nvm_burn_enable;
    logic [3:0] burn_addr;
    logic self_test_select;
    logic nvm_burn_in_progress;
    logic [9:0] burn_cnt;
    logic burn_pulse;
    logic [3:0] burn_out_addr;
    logic [15:0] nvm_s1;
    logic [15:0] nvm_s2;
    logic [15:0] nvm_s3;
    logic [15:0] stored;
    logic cal_start;
    logic [23:0] rdata;
    logic [3:0] fine_out;
    logic use_stored;
  } rcotp_regs_t;

  logic [1:0] reset_pipe;
  logic reset_n_sync;
  rcotp_regs_t q;
  rcotp_regs_t n;
  rcotp_eng_if eng ();

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reset_pipe <= 2'b00;
    end else begin
      reset_pipe <= {reset_pipe[0], 1'b1};
    end
  end
  assign reset_n_sync = reset_pipe[1];

  function automatic logic [23:0] read_mux(input logic [4:0] addr, input rcotp_regs_t s,
      input logic busy, input logic running, input logic [3:0] fine,
      input logic [23:0] raw, input logic [15:0] sig);
    logic [23:0] r;
    r = 24'h000000;
    unique case (addr)
      rcotp_pkg::ADDR_REF_PERIOD: r = {9'h000, s.ref_period};
      rcotp_pkg::ADDR_CORRECTION: r = {15'h0000, s.correction};
      rcotp_pkg::ADDR_CAL_STATUS: r = {18'h00000, s.nvm_burn_in_progress, busy, fine};
      rcotp_pkg::ADDR_RAW_COUNT: r = raw;
      rcotp_pkg::ADDR_STORED: r = {9'h000, s.stored[rcotp_pkg::STORED_USED_W-1:0]};
      rcotp_pkg::ADDR_BURN_ENABLE: r = {23'h000000, s.nvm_burn_enable};
      rcotp_pkg::ADDR_BURN_ADDR: r = {20'h00000, s.burn_addr};
      rcotp_pkg::ADDR_ST_ENABLE: r = {23'h000000, s.self_test_select};
      rcotp_pkg::ADDR_ST_RESULT: r = {7'h00, running, sig};
      default: r = 24'h000000;
    endcase
    return r;
  endfunction

  always_comb begin
    n = q;
    n.cal_start = 1'b0;
    n.nvm_s1 = i_nvm_bits;
    n.nvm_s2 = q.nvm_s1;
    n.nvm_s3 = q.nvm_s2;
    n.stored = (q.nvm_s2 & q.nvm_s3) | (q.stored & (q.nvm_s2 ^ q.nvm_s3));
    if (q.nvm_burn_in_progress) begin
      n.burn_cnt = q.burn_cnt + 10'h001;
      if (q.burn_cnt == rcotp_pkg::BURN_LAST) begin
        n.nvm_burn_in_progress = 1'b0;
        n.burn_pulse = 1'b0;
      end
    end
    if (i_reg_write) begin
      unique case (i_reg_addr)
        rcotp_pkg::ADDR_CAL_STROBE: begin
          if (!eng.cal_busy && !q.cal_start) begin
            n.cal_start = 1'b1;
          end
        end
        rcotp_pkg::ADDR_REF_PERIOD: n.ref_period = i_reg_wdata[14:0];
        rcotp_pkg::ADDR_CORRECTION: n.correction = i_reg_wdata[8:0];
        rcotp_pkg::ADDR_BURN_ENABLE: n.nvm_burn_enable = i_reg_wdata[0];
        rcotp_pkg::ADDR_BURN_ADDR: n.burn_addr = i_reg_wdata[3:0];
        rcotp_pkg::ADDR_BURN_STROBE: begin
          if (q.nvm_burn_enable && !q.nvm_burn_in_progress) begin
            n.nvm_burn_in_progress = 1'b1;
            n.burn_pulse = 1'b1;
            n.burn_cnt = 10'h000;
            n.burn_out_addr = q.burn_addr;
          end
        end
        rcotp_pkg::ADDR_ST_ENABLE: n.self_test_select = i_reg_wdata[0];
        default: begin
        end
      endcase
    end
    if (i_reg_read) begin
      n.rdata = read_mux(i_reg_addr, q, eng.cal_busy, eng.st_running, eng.fine_code,
        eng.raw_count, eng.signature);
    end
    n.use_stored = !i_ignore_stored_values && q.stored[rcotp_pkg::STORED_PRG_FLAG_BIT];
    if (i_force_fine) begin
      n.fine_out = i_fine_override;
    end else if (n.use_stored) begin
      n.fine_out = q.stored[3:0];
    end else begin
      n.fine_out = eng.fine_code;
    end
  end

  always_ff @(posedge i_clock or negedge reset_n_sync) begin
    if (!reset_n_sync) begin
      q <= '{ref_period: rcotp_pkg::REF_PERIOD_RST, correction: rcotp_pkg::CORR_RST,
        nvm_burn_enable: 1'b0, burn_addr: rcotp_pkg::BURN_ADDR_RST, self_test_select: 1'b0,
        nvm_burn_in_progress: 1'b0, burn_cnt: 10'h000, burn_pulse: 1'b0,
        burn_out_addr: rcotp_pkg::BURN_ADDR_RST, nvm_s1: 16'h0000, nvm_s2: 16'h0000,
        nvm_s3: 16'h0000, stored: 16'h0000, cal_start: 1'b0, rdata: 24'h000000,
        fine_out: 4'h0, use_stored: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign eng.start = q.cal_start;
  assign eng.self_test = q.self_test_select;
  assign eng.ref_period = q.ref_period;
  assign eng.correction = q.correction;

  rcotp_engine u_engine (
    .i_clock(i_clock),
    .i_reset_n(reset_n_sync),
    .i_rc_threshold(i_rc_threshold),
    .bus(eng)
  );

  assign o_reg_rdata = q.rdata;
  assign o_fine_code = q.fine_out;
  assign o_use_stored = q.use_stored;
  assign o_nvm_burn_pulse = q.burn_pulse;
  assign o_nvm_burn_addr = q.burn_out_addr;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!reset_n_sync);

  cal_strobe_start_a: assert property (i_reg_write && i_reg_addr == rcotp_pkg::ADDR_CAL_STROBE
    && !eng.cal_busy && !q.cal_start |=> ##1 eng.cal_busy)
    else $error("calibration strobe did not start a cycle");
  self_test_start_a: assert property ($rose(eng.cal_busy) && $past(q.self_test_select)
    |-> eng.st_running)
    else $error("self-test not started in self-test mode");
  fine_code_range_a: assert property (eng.fine_code <= rcotp_pkg::FINE_MAX)
    else $error("fine code above eleven");
  force_override_a: assert property (i_force_fine && reset_n_sync
    |=> o_fine_code == $past(i_fine_override))
    else $error("override fine code not applied");
  ignore_stored_a: assert property (!q.stored[rcotp_pkg::STORED_PRG_FLAG_BIT]
    |=> !o_use_stored)
    else $error("stored values used without programmed flag");
  stored_fine_used_a: assert property (!i_force_fine && n.use_stored
    |=> o_fine_code == $past(q.stored[3:0]))
    else $error("stored fine code not applied");
  burn_gate_a: assert property ($rose(o_nvm_burn_pulse) |-> $past(q.nvm_burn_enable)
    && $past(i_reg_write) && $past(i_reg_addr) == rcotp_pkg::ADDR_BURN_STROBE
    && o_nvm_burn_addr == $past(q.burn_addr))
    else $error("burn pulse without enable and strobe");
  burn_pulse_len_a: assert property ($rose(o_nvm_burn_pulse) |-> o_nvm_burn_pulse [*8])
    else $error("burn pulse too short");
  burn_pulse_end_a: assert property ($fell(o_nvm_burn_pulse)
    |-> $past(q.burn_cnt) == rcotp_pkg::BURN_LAST)
    else $error("burn pulse length wrong");
  status_read_a: assert property (i_reg_read && i_reg_addr == rcotp_pkg::ADDR_CAL_STATUS
    |=> o_reg_rdata[rcotp_pkg::STATUS_BURN_BIT] == $past(q.nvm_burn_in_progress)
    && o_reg_rdata[rcotp_pkg::STATUS_CAL_BUSY_BIT] == $past(eng.cal_busy))
    else $error("status busy bits wrong");
  raw_read_a: assert property (i_reg_read && i_reg_addr == rcotp_pkg::ADDR_RAW_COUNT
    |=> o_reg_rdata == $past(eng.raw_count))
    else $error("raw count readback wrong");
  st_result_read_a: assert property (i_reg_read && i_reg_addr == rcotp_pkg::ADDR_ST_RESULT
    |=> o_reg_rdata[rcotp_pkg::ST_RUN_BIT] == $past(eng.st_running))
    else $error("self-test running bit wrong");

  cover_calibration_c: cover property ($fell(eng.cal_busy) && !q.self_test_select);
  cover_burn_c: cover property ($fell(o_nvm_burn_pulse));
  cover_stored_c: cover property (o_use_stored && !i_force_fine);
endmodule
`default_nettype wire

// >>> tb/rcotp_far_model.sv
`default_nettype none
module rcotp_far_model #(
  parameter int DELAY = 60
) (
  input wire logic i_clock,
  input wire logic i_arm,
  input wire logic i_burn_pulse,
  input wire logic [3:0] i_burn_addr,
  output logic o_threshold,
  output logic [15:0] o_fuses
);
  timeunit 1ns;
  timeprecision 1ps;
  int count;
  // Comparator trips a fixed time after the filter starts charging
  always @(posedge i_clock) begin
    if (!i_arm) begin
      count <= 0;
    end else if (count < DELAY) begin
      count <= count + 1;
    end
  end
  assign o_threshold = i_arm && (count >= DELAY);
  // Fuses are nonvolatile: no reset, a bit blows while its pulse is applied
  logic [15:0] fuse_q = 16'h0000;
  always @(posedge i_clock) begin
    if (i_burn_pulse) begin
      fuse_q[i_burn_addr] <= 1'b1;
    end
  end
  assign o_fuses = fuse_q;
endmodule
`default_nettype wire

// >>> tb/tb_rcotp_regs.sv
`default_nettype none
module tb_rcotp_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [23:0] wdata;
    logic [23:0] exp;
  } rcotp_row_t;
  localparam int REF = 2000;
  logic clock, reset_n, reg_write, reg_read, threshold, ignore_stored, force_fine, arm;
  logic use_stored, burn_pulse;
  logic [4:0] reg_addr;
  logic [23:0] reg_wdata, rdata, seen;
  logic [3:0] fine_override, fine_code, burn_addr;
  logic [15:0] fuses;
  logic [3:0] bits [4] = '{4'hD, 4'h3, 4'hE, 4'hF};
  int err_count = 0;
  int checked = 0;
  rcotp_row_t rows [24] = '{
    '{1'b0, rcotp_pkg::ADDR_REF_PERIOD, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_CORRECTION, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_BURN_ENABLE, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_BURN_ADDR, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_ST_ENABLE, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_ST_RESULT, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_CAL_STATUS, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_RAW_COUNT, 24'h0, 24'h0},
    '{1'b0, 5'h07, 24'h0, 24'h0},
    '{1'b0, 5'h10, 24'h0, 24'h0},
    '{1'b0, 5'h1A, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_CAL_STROBE, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_BURN_STROBE, 24'h0, 24'h0},
    '{1'b0, rcotp_pkg::ADDR_STORED, 24'h0, 24'h0},
    '{1'b1, rcotp_pkg::ADDR_REF_PERIOD, 24'hFFFFFF, 24'h007FFF},
    '{1'b1, rcotp_pkg::ADDR_CORRECTION, 24'hFFFFFF, 24'h0001FF},
    '{1'b1, rcotp_pkg::ADDR_BURN_ADDR, 24'hFFFFFF, 24'h00000F},
    '{1'b1, rcotp_pkg::ADDR_ST_ENABLE, 24'hFFFFFF, 24'h000001},
    '{1'b1, rcotp_pkg::ADDR_ST_ENABLE, 24'h000000, 24'h000000},
    '{1'b1, rcotp_pkg::ADDR_RAW_COUNT, 24'hFFFFFF, 24'h000000},
    '{1'b1, rcotp_pkg::ADDR_ST_RESULT, 24'hFFFFFF, 24'h000000},
    '{1'b1, 5'h12, 24'hFFFFFF, 24'h000000},
    '{1'b1, rcotp_pkg::ADDR_REF_PERIOD, 24'h0061A8, 24'h0061A8},
    '{1'b1, rcotp_pkg::ADDR_REF_PERIOD, 24'h0007D0, 24'h0007D0}
  };

  rcotp_regs i_rcotp_regs (.i_clock(clock), .i_reset_n(reset_n), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_write(reg_write), .i_reg_read(reg_read),
    .i_rc_threshold(threshold), .i_nvm_bits(fuses), .i_ignore_stored_values(ignore_stored),
    .i_force_fine(force_fine), .i_fine_override(fine_override), .o_reg_rdata(rdata),
    .o_fine_code(fine_code), .o_use_stored(use_stored), .o_nvm_burn_pulse(burn_pulse),
    .o_nvm_burn_addr(burn_addr));
  rcotp_far_model #(.DELAY(60)) i_rcotp_far_model (.i_clock(clock), .i_arm(arm),
    .i_burn_pulse(burn_pulse), .i_burn_addr(burn_addr), .o_threshold(threshold),
    .o_fuses(fuses));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // Expected self-test signature: one step per cycle over the running sum
  function automatic logic [15:0] crc_model(input logic [23:0] step);
    logic [15:0] c;
    logic [23:0] a;
    logic [15:0] d;
    c = rcotp_pkg::CRC_INIT;
    a = 24'h000000;
    for (int i = 0; i <= int'(rcotp_pkg::SELF_TEST_LAST); i++) begin
      d = a[15:0] ^ a[23:8];
      for (int j = 15; j >= 0; j--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[j]) ? rcotp_pkg::CRC_POLY : 16'h0000);
      end
      a = a + step;
    end
    return c;
  endfunction

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    @(negedge clock);
    d = rdata;
  endtask

  task automatic wait_clear(input logic [4:0] a, input int b);
    int n;
    n = 0;
    seen = 24'hFFFFFF;
    while (seen[b] !== 1'b0 && n < 40) begin
      rd(a, seen);
      n++;
    end
    check(24'(seen[b]), 24'h0);
  endtask

  task automatic run_rows(input int n);
    for (int i = 0; i < n; i++) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].wdata);
      end
      rd(rows[i].addr, seen);
      check(seen, rows[i].exp);
    end
  endtask

  task automatic calibrate(input logic [8:0] corr);
    int cs, raw, adj, code;
    logic [23:0] st;
    wr(rcotp_pkg::ADDR_CORRECTION, {15'h0, corr});
    arm = 1'b1;
    wr(rcotp_pkg::ADDR_CAL_STROBE, 24'h5A5A5A);
    repeat (2) @(negedge clock);
    rd(rcotp_pkg::ADDR_CAL_STATUS, st);
    check(24'(st[4]), 24'h1);
    wait_clear(rcotp_pkg::ADDR_CAL_STATUS, 4);
    arm = 1'b0;
    rd(rcotp_pkg::ADDR_RAW_COUNT, st);
    raw = int'(st);
    check(24'((raw % REF == 0) && raw >= 55 * REF && raw <= 75 * REF), 24'h1);
    cs = corr[8] ? int'(corr) - 512 : int'(corr);
    adj = raw + cs * 1024;
    code = 0;
    for (int k = 1; k <= 11; k++) begin
      if (adj >= int'(rcotp_pkg::FINE_BASE_PS) + k * int'(rcotp_pkg::FINE_STEP_PS)) begin
        code = k;
      end
    end
    rd(rcotp_pkg::ADDR_CAL_STATUS, st);
    check(st, 24'(code));
    check(24'(fine_code), 24'(code));
  endtask

  task automatic close_out();
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #150us;
    err_count++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
    ignore_stored = 1'b0;
    force_fine = 1'b0;
    fine_override = 4'h0;
    arm = 1'b0;
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    run_rows(24);
    calibrate(9'h000);
    calibrate(9'h1EC);
    calibrate(9'h064);
    calibrate(9'h101);
    // Self-test run
    wr(rcotp_pkg::ADDR_ST_ENABLE, 24'h000001);
    wr(rcotp_pkg::ADDR_CAL_STROBE, 24'h000000);
    repeat (2) @(negedge clock);
    rd(rcotp_pkg::ADDR_ST_RESULT, seen);
    check(24'(seen[16]), 24'h1);
    repeat (200) @(negedge clock);
    rd(rcotp_pkg::ADDR_ST_RESULT, seen);
    check(24'(seen[16]), 24'h1);
    wait_clear(rcotp_pkg::ADDR_ST_RESULT, 16);
    check(24'(seen[23:16]), 24'h0);
    check({8'h00, seen[15:0]}, {8'h00, crc_model(24'(REF))});
    rd(rcotp_pkg::ADDR_RAW_COUNT, seen);
    check(seen, 24'(int'(rcotp_pkg::SELF_TEST_LAST) * REF));
    wr(rcotp_pkg::ADDR_ST_ENABLE, 24'h000000);
    // Strobe without burn enable is refused
    wr(rcotp_pkg::ADDR_BURN_STROBE, 24'h000000);
    @(negedge clock);
    check(24'(burn_pulse), 24'h0);
    check(24'(use_stored), 24'h0);
    wr(rcotp_pkg::ADDR_BURN_ENABLE, 24'h000001);
    foreach (bits[i]) begin
      wr(rcotp_pkg::ADDR_BURN_ADDR, 24'(bits[i]));
      wr(rcotp_pkg::ADDR_BURN_STROBE, 24'h000000);
      @(negedge clock);
      check({19'h0, burn_pulse, burn_addr}, {19'h0, 1'b1, bits[i]});
      rd(rcotp_pkg::ADDR_CAL_STATUS, seen);
      check(24'(seen[5]), 24'h1);
      repeat (990) @(negedge clock);
      check(24'(burn_pulse), 24'h1);
      repeat (10) @(negedge clock);
      check(24'(burn_pulse), 24'h0);
    end
    repeat (5) @(negedge clock);
    rd(rcotp_pkg::ADDR_STORED, seen);
    check(seen, 24'h006008);
    check(24'(use_stored), 24'h1);
    check(24'(fine_code), 24'h000008);
    ignore_stored = 1'b1;
    repeat (2) @(negedge clock);
    check(24'(use_stored), 24'h0);
    force_fine = 1'b1;
    fine_override = 4'h5;
    repeat (2) @(negedge clock);
    check(24'(fine_code), 24'h000005);
    // Second reset in mid-run
    reset_n = 1'b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    run_rows(13);
    close_out();
  end
endmodule
`default_nettype wire
